/* pkg/unb_pkg.sv */
// constants shared by the nine-bit serial port and its baud generator
package unb_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_CONTROL  = 4'h0; // serial_control
  localparam logic [3:0] ADDR_BUFFER   = 4'h1; // serial_buffer
  localparam logic [3:0] ADDR_BAUD     = 4'h2; // baud configuration
  localparam logic [3:0] ADDR_T1RELOAD = 4'h3; // timer1_reload_value
  localparam logic [3:0] ADDR_T2LOW    = 4'h4; // timer2_reload_low
  localparam logic [3:0] ADDR_T2HIGH   = 4'h5; // timer2_reload_high
  localparam logic [3:0] ADDR_STATUS   = 4'h6; // engine status, read only

  // serial_control field positions
  localparam int CTL_RX_DONE   = 0; // rx_done_flag
  localparam int CTL_TX_DONE   = 1; // tx_done_flag
  localparam int CTL_RX_NINTH  = 2; // rx_ninth_bit
  localparam int CTL_TX_NINTH  = 3; // tx_ninth_bit
  localparam int CTL_RX_EN     = 4; // receive_enable_bit
  localparam int CTL_MULTIPROC = 5; // multiproc_enable
  localparam int CTL_SHIFT     = 6; // fixed shift-rate pacing of transmit

  // baud configuration field positions
  localparam int BAUD_DOUBLE = 0; // baud_double
  localparam int BAUD_USE_T2 = 1; // timer 2 as baud source
  localparam int BAUD_T1FAST = 2; // timer 1 prescale 4 instead of 12

  // status field positions
  localparam int STAT_TX_BUSY = 0;
  localparam int STAT_RX_BUSY = 1;

  // reset values
  localparam logic [6:0]  RST_CONTROL  = 7'h00;
  localparam logic [2:0]  RST_BAUD     = 3'h0;
  localparam logic [7:0]  RST_T1RELOAD = 8'h00;
  localparam logic [15:0] RST_T2RELOAD = 16'h0000;

  // timing counts in oscillator clocks (last count value of each divider)
  localparam logic [3:0] T1_PRE_SLOW_LAST = 4'hb; // divide by 12
  localparam logic [3:0] T1_PRE_FAST_LAST = 4'h3; // divide by 4
  localparam logic [3:0] SHIFT_SLOW_LAST  = 4'hb; // divide by 12
  localparam logic [3:0] SHIFT_FAST_LAST  = 4'h3; // divide by 4
  localparam logic [7:0]  T1_MAX = 8'hff;
  localparam logic [15:0] T2_MAX = 16'hffff;

  // oversampling and frame layout
  localparam logic [3:0] OVS_LAST   = 4'hf; // divide by 16
  localparam logic [3:0] SAMPLE_A   = 4'h7; // three mid-bit samples
  localparam logic [3:0] SAMPLE_B   = 4'h8;
  localparam logic [3:0] SAMPLE_C   = 4'h9;
  localparam logic [3:0] FRAME_BITS = 4'hb; // 11 bits per frame
  localparam logic [3:0] NINTH_IDX  = 4'h9; // position of the ninth bit
  localparam logic [3:0] STOP_IDX   = 4'ha; // position of the stop bit
endpackage

/* design/unb_baud_gen.sv */
// baud timers: timer overflow oversample tick and fixed shift-rate tick
`timescale 1ns/1ps
module unb_baud_gen
  import unb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        t1Fast,
  input  wire logic        baudDouble,
  input  wire logic        useTimer2,
  input  wire logic        multiprocEnable,
  input  wire logic [7:0]  t1Reload,
  input  wire logic [15:0] t2Reload,
  output logic             ovsTick,
  output logic             shiftTick
);
  logic [3:0]  t1Pre_r;   // timer 1 prescaler
  logic [7:0]  t1Cnt_r;   // timer 1 8-bit auto-reload count
  logic        t2Ph_r;    // timer 2 runs at half the oscillator
  logic [15:0] t2Cnt_r;   // timer 2 16-bit auto-reload count
  logic        half_r;    // timer 1 overflow divide-by-two phase
  logic [3:0]  shCnt_r;   // shift-rate divider
  logic [3:0]  t1PreLast; // prescale end value
  logic [3:0]  shLast;    // shift divider end value
  logic        t1Inc;     // timer 1 count step
  logic        t1Ovf;     // timer 1 passes ff
  logic        t2Ovf;     // timer 2 passes ffff
  logic [7:0]  t1Seen_r;  // timer 1 reload in use, a new one restarts the count
  logic [15:0] t2Seen_r;  // timer 2 reload in use, a new one restarts the count
  logic        t1New;     // software changed the timer 1 reload
  logic        t2New;     // software changed the timer 2 reload

  // decode of divider ends and overflows
  always_comb begin
    t1PreLast = t1Fast ? T1_PRE_FAST_LAST : T1_PRE_SLOW_LAST;
    shLast    = multiprocEnable ? SHIFT_FAST_LAST : SHIFT_SLOW_LAST;
    t1Inc     = (t1Pre_r >= t1PreLast); // count left above a new end wraps at once
    t1Ovf     = t1Inc && (t1Cnt_r == T1_MAX);
    t2Ovf     = t2Ph_r && (t2Cnt_r == T2_MAX);
    t1New     = (t1Reload != t1Seen_r);
    t2New     = (t2Reload != t2Seen_r);
  end

  // timer 1: prescaled, reloads on overflow
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      t1Pre_r  <= 4'h0;
      t1Cnt_r  <= 8'h00;
      t1Seen_r <= RST_T1RELOAD;
    end else begin
      t1Seen_r <= t1Reload;
      if (t1New) begin
        // count is not software visible: a new reload restarts it at once
        t1Pre_r <= 4'h0;
        t1Cnt_r <= t1Reload;
      end else begin
        t1Pre_r <= t1Inc ? 4'h0 : t1Pre_r + 4'h1;
        if (t1Ovf) begin
          t1Cnt_r <= t1Reload;
        end else if (t1Inc) begin
          t1Cnt_r <= t1Cnt_r + 8'h01;
        end
      end
    end
  end

  // timer 2: oscillator over two, 16-bit reload gives fosc/(32*(65536-reload)) per bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      t2Ph_r   <= 1'b0;
      t2Cnt_r  <= 16'h0000;
      t2Seen_r <= RST_T2RELOAD;
    end else begin
      t2Ph_r   <= ~t2Ph_r;
      t2Seen_r <= t2Reload;
      if (t2New) begin
        // avoids a full 16-bit run from zero before the first overflow
        t2Cnt_r <= t2Reload;
      end else if (t2Ovf) begin
        t2Cnt_r <= t2Reload;
      end else if (t2Ph_r) begin
        t2Cnt_r <= t2Cnt_r + 16'h0001;
      end
    end
  end

  // overflow pulse selection; timer 1 halved unless doubling is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r  <= 1'b0;
      ovsTick <= 1'b0;
    end else begin
      if (t1Ovf) begin
        half_r <= ~half_r;
      end
      if (useTimer2) begin
        ovsTick <= t2Ovf;
      end else begin
        ovsTick <= t1Ovf && (baudDouble || half_r);
      end
    end
  end

  // fixed shift-rate tick, fosc/12 or fosc/4
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shCnt_r   <= 4'h0;
      shiftTick <= 1'b0;
    end else begin
      // a count above a newly smaller end wraps at once instead of running to 15
      shCnt_r   <= (shCnt_r >= shLast) ? 4'h0 : shCnt_r + 4'h1;
      shiftTick <= (shCnt_r >= shLast);
    end
  end
endmodule

/* design/unb_serial_port.sv */
// nine-bit asynchronous serial port with register port and baud timers
// Contract
// - frame: start, 8 data LSB first, ninth, stop
// - transmit ninth bit comes from tx_ninth_bit
// - receive ninth bit to rx_ninth_bit; stop ignored
// - buffer write starts frame after next rollover
// - tx_done_flag set when stop bit driven
// - receive only when enabled, from falling edge
// - sixteen samples per bit at any rate
// - start edge resets receive divide-by-16 counter
// - bit value is majority of three mid samples
// - mid-stop check: rx_done_flag clear, multiproc condition
// - accept loads buffer, ninth bit, sets flag
// - after stop middle, return to idle
// - multiproc mode accepts only ninth bit one
// - shift rate fosc/12, or fosc/4 with multiproc
// - timer overflows divided by sixteen form bit
// - port may choose timer 1 or timer 2
// - baud_double skips timer 1 divide by two
// - timer 2 rate fosc/(32*(65536-reload))
`timescale 1ns/1ps
module unb_serial_port
  import unb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       rxdPin,
  output logic            txdPin
);
  typedef enum logic [0:0] {RX_IDLE, RX_FRAME} unb_rx_state_t;

  logic [6:0]    control_r;   // serial_control fields
  logic [2:0]    baud_r;      // baud configuration
  logic [7:0]    t1Reload_r;  // timer1_reload_value
  logic [15:0]   t2Reload_r;  // timer2_reload_high : timer2_reload_low
  logic [7:0]    rxBuf_r;     // received byte as read from serial_buffer
  logic [7:0]    txData_r;    // byte written for transmit
  logic          txPending_r; // write seen, waiting for rollover
  logic          txBusy_r;    // frame on the line
  logic [3:0]    txDiv_r;     // transmit divide-by-16
  logic [3:0]    txBit_r;     // next frame bit index
  logic [10:0]   txFrame_r;   // frame captured at start
  logic          txDoneSet_r; // pulse: stop bit now on pin
  logic          rxS1_r;      // pin synchroniser stage 1
  logic          rxS2_r;      // stage 2
  logic          rxS3_r;      // stage 3
  logic          rxLine_r;    // filtered receive level
  logic          rxPrev_r;    // previous filtered level
  unb_rx_state_t rxState_r;   // receive engine state
  logic [3:0]    rxDiv_r;     // receive divide-by-16
  logic [3:0]    rxBit_r;     // frame bit index being received
  logic [2:0]    rxVote_r;    // three mid-bit samples
  logic [8:0]    rxShift_r;   // data plus ninth bit
  logic          rxLoad_r;    // pulse: frame accepted
  logic          rxNinth_r;   // ninth bit of accepted frame
  logic          ovsTick;     // oversample tick from baud timers
  logic          shiftTick;   // fixed shift-rate tick
  logic          txBoundary;  // transmit bit boundary
  logic          rxMajority;  // vote result
  logic          rxAccept;    // acceptance at mid-stop
  logic [10:0]   frameNext;   // frame to send

  // baud timers
  unb_baud_gen u_baud (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .t1Fast          (baud_r[BAUD_T1FAST]),
    .baudDouble      (baud_r[BAUD_DOUBLE]),
    .useTimer2       (baud_r[BAUD_USE_T2]),
    .multiprocEnable (control_r[CTL_MULTIPROC]),
    .t1Reload        (t1Reload_r),
    .t2Reload        (t2Reload_r),
    .ovsTick         (ovsTick),
    .shiftTick       (shiftTick)
  );

  // combinational helpers for both engines
  always_comb begin
    // bit boundary: rollover of divide-by-16, or the fixed shift rate
    if (control_r[CTL_SHIFT]) begin
      txBoundary = shiftTick;
    end else begin
      txBoundary = ovsTick && (txDiv_r == OVS_LAST);
    end
    // two of three samples decide the bit
    rxMajority = (rxVote_r[0] & rxVote_r[1]) | (rxVote_r[0] & rxVote_r[2])
               | (rxVote_r[1] & rxVote_r[2]);
    // flag clear and, in multiprocessor mode, ninth bit high
    rxAccept = !control_r[CTL_RX_DONE]
             && (!control_r[CTL_MULTIPROC] || rxShift_r[8]);
    // stop, ninth, data LSB first, start
    frameNext = {1'b1, control_r[CTL_TX_NINTH], txData_r, 1'b0};
  end

  // register writes and flag handling; hardware set beats software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_r  <= RST_CONTROL;
      baud_r     <= RST_BAUD;
      t1Reload_r <= RST_T1RELOAD;
      t2Reload_r <= RST_T2RELOAD;
    end else begin
      if (regWrite) begin
        unique case (regAddr)
          ADDR_CONTROL:  control_r  <= regWrData[6:0];
          ADDR_BAUD:     baud_r     <= regWrData[2:0];
          ADDR_T1RELOAD: t1Reload_r <= regWrData;
          ADDR_T2LOW:    t2Reload_r[7:0]  <= regWrData;
          ADDR_T2HIGH:   t2Reload_r[15:8] <= regWrData;
          default: ;     // buffer write taken by the transmit block; unmapped or read-only, ignored
        endcase
      end
      // completion of transmit
      if (txDoneSet_r) begin
        control_r[CTL_TX_DONE] <= 1'b1;
      end
      // accepted frame updates ninth bit and flag
      if (rxLoad_r) begin
        control_r[CTL_RX_DONE]  <= 1'b1;
        control_r[CTL_RX_NINTH] <= rxNinth_r;
      end
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_CONTROL:  regRdData <= {1'b0, control_r};
        ADDR_BUFFER:   regRdData <= rxBuf_r;
        ADDR_BAUD:     regRdData <= {5'h00, baud_r};
        ADDR_T1RELOAD: regRdData <= t1Reload_r;
        ADDR_T2LOW:    regRdData <= t2Reload_r[7:0];
        ADDR_T2HIGH:   regRdData <= t2Reload_r[15:8];
        ADDR_STATUS:   regRdData <= {6'h00, (rxState_r == RX_FRAME), txBusy_r};
        default:       regRdData <= 8'h00; // unmapped reads zero
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // transmit divide-by-16, free running on the oversample tick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txDiv_r <= 4'h0;
    end else if (ovsTick) begin
      txDiv_r <= txDiv_r + 4'h1;
    end
  end

  // buffer write captures byte and arms a transmission
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txData_r    <= 8'h00;
      txPending_r <= 1'b0;
    end else begin
      if (regWrite && (regAddr == ADDR_BUFFER)) begin
        txData_r    <= regWrData;
        txPending_r <= 1'b1;
      end else if (txBoundary && !txBusy_r) begin
        txPending_r <= 1'b0;
      end
    end
  end

  // transmit shifter: one frame bit per boundary
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txdPin      <= 1'b1;
      txBusy_r    <= 1'b0;
      txBit_r     <= 4'h0;
      txFrame_r   <= 11'h7ff;
      txDoneSet_r <= 1'b0;
    end else begin
      txDoneSet_r <= 1'b0;
      if (txBoundary) begin
        if (!txBusy_r) begin
          // start bit only after rollover that follows the write
          if (txPending_r && !(regWrite && (regAddr == ADDR_BUFFER))) begin
            txFrame_r <= frameNext;
            txdPin    <= 1'b0;
            txBit_r   <= 4'h1;
            txBusy_r  <= 1'b1;
          end
        end else if (txBit_r == FRAME_BITS) begin
          // stop bit period over, line stays high
          txBusy_r <= 1'b0;
          txBit_r  <= 4'h0;
          txdPin   <= 1'b1;
        end else begin
          txdPin  <= txFrame_r[txBit_r];
          txBit_r <= txBit_r + 4'h1;
          if (txBit_r == STOP_IDX) begin
            txDoneSet_r <= 1'b1;
          end
        end
      end
    end
  end

  // receive pin: three flops, change taken once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxS1_r   <= 1'b1;
      rxS2_r   <= 1'b1;
      rxS3_r   <= 1'b1;
      rxLine_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxS1_r   <= rxdPin;
      rxS2_r   <= rxS1_r;
      rxS3_r   <= rxS2_r;
      rxPrev_r <= rxLine_r;
      if (rxS2_r == rxS3_r) begin
        rxLine_r <= rxS3_r;
      end
    end
  end

  // receive engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= RX_IDLE;
      rxDiv_r   <= 4'h0;
      rxBit_r   <= 4'h0;
      rxVote_r  <= 3'h7;
      rxShift_r <= 9'h000;
      rxLoad_r  <= 1'b0;
      rxNinth_r <= 1'b0;
    end else begin
      rxLoad_r <= 1'b0;
      unique case (rxState_r)
        RX_IDLE: begin
          // high line is idle; a falling edge opens a frame
          if (control_r[CTL_RX_EN] && rxPrev_r && !rxLine_r) begin
            rxDiv_r   <= 4'h0;
            rxBit_r   <= 4'h0;
            rxState_r <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          if (ovsTick) begin
            rxDiv_r <= rxDiv_r + 4'h1;
            // collect three consecutive mid-bit samples
            if (rxDiv_r == SAMPLE_A || rxDiv_r == SAMPLE_B) begin
              rxVote_r <= {rxVote_r[1:0], rxLine_r};
            end
            if (rxDiv_r == SAMPLE_C) begin
              rxVote_r <= {rxVote_r[1:0], rxLine_r};
            end
            // decide the bit one tick after the third sample
            if (rxDiv_r == SAMPLE_C + 4'h1) begin
              if (rxBit_r == 4'h0) begin
                // start bit read high: glitch, back to idle
                if (rxMajority) begin
                  rxState_r <= RX_IDLE;
                end
              end else if (rxBit_r == STOP_IDX) begin
                // stop value itself is not checked
                if (rxAccept) begin
                  rxLoad_r  <= 1'b1;
                  rxNinth_r <= rxShift_r[8];
                end
                rxState_r <= RX_IDLE;
              end else begin
                // data LSB first, ninth bit ends in the top position
                rxShift_r <= {rxMajority, rxShift_r[8:1]};
              end
              rxBit_r <= rxBit_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // received byte into serial_buffer only on acceptance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_r <= 8'h00;
    end else if (rxLoad_r) begin
      rxBuf_r <= rxShift_r[7:0];
    end
  end
endmodule

/* verification/unb_port_properties.sv */
// concurrent checks on the serial port register port and pins
`timescale 1ns/1ps
module unb_port_properties
  import unb_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic       rxdPin,
  input wire logic       txdPin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [6:0] ctlShadow_r; // last control value written by software

  // shadow of software writes to the control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      ctlShadow_r <= RST_CONTROL;
    else if (regWrite && regAddr == ADDR_CONTROL)
      ctlShadow_r <= regWrData[6:0];
  end

  // one-cycle strobes at a given address
  sequence wrAt(a); regWrite && regAddr == a; endsequence
  sequence rdAt(a); regRead && regAddr == a; endsequence

  a_rd_gap_zero: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside the read slot");
  a_unmapped_zero: assert property (
    regRead && regAddr > ADDR_STATUS |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_t2_low_back: assert property (
    wrAt(ADDR_T2LOW) ##1 rdAt(ADDR_T2LOW) |=> regRdData == $past(regWrData, 2))
    else $error("timer 2 low reload readback wrong");
  a_t1_reload_back: assert property (
    wrAt(ADDR_T1RELOAD) ##1 rdAt(ADDR_T1RELOAD) |=> regRdData == $past(regWrData, 2))
    else $error("timer 1 reload readback wrong");
  a_ctl_back: assert property (
    wrAt(ADDR_CONTROL) ##1 rdAt(ADDR_CONTROL)
      |=> regRdData[6:3] == $past(regWrData[6:3], 2))
    else $error("control readback wrong");
  a_idle_after_reset: assert property ($rose(rst_n) |-> txdPin)
    else $error("transmit line not idle high after reset");
  a_low_run_min: assert property ($fell(txdPin) |=> !txdPin [*3])
    else $error("low bit shorter than four cycles");
  a_high_run_min: assert property ($rose(txdPin) |=> txdPin [*3])
    else $error("high bit shorter than four cycles");
  a_rx_off_quiet: assert property (
    regRead && regAddr == ADDR_CONTROL && !ctlShadow_r[CTL_RX_EN]
      && !ctlShadow_r[CTL_RX_DONE] |=> !regRdData[CTL_RX_DONE])
    else $error("receive flag set while receive disabled");
  a_tx_flag_sticky: assert property (
    regRead && regAddr == ADDR_CONTROL && ctlShadow_r[CTL_TX_DONE]
      |=> regRdData[CTL_TX_DONE])
    else $error("transmit flag lost without a clearing write");
endmodule

/* verification/unb_remote_node.sv */
// remote serial node model facing the serial pins
`timescale 1ns/1ps
module unb_remote_node (
  input  wire logic ref_clk,
  input  wire logic txdPin,
  output logic      rxdLine
);
  initial rxdLine = 1'b1; // idle line high

  // send one frame; gl flips two cycles mid bit for noise
  task automatic send(input logic [7:0] d, input logic n, input logic s,
                      input int bc, input bit gl);
    logic [10:0] f;
    f = {s, n, d, 1'b0}; // start, data lsb first, ninth, stop
    for (int i = 0; i < 11; i++) begin
      for (int c = 0; c < bc; c++) begin
        @(posedge ref_clk);
        rxdLine <= (gl && i < 10 && c >= bc / 2 && c < bc / 2 + 2) ? ~f[i] : f[i];
      end
    end
    @(posedge ref_clk);
    rxdLine <= 1'b1; // back to idle high
  endtask

  // capture one frame at mid bit; wt counts cycles to the start edge
  task automatic recv(input int bc, output logic [10:0] f, output int wt);
    wt = 0;
    while (txdPin !== 1'b0 && wt < 4000) begin
      @(posedge ref_clk);
      wt++;
    end
    repeat (bc / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txdPin; // eleven bits per frame
      repeat (bc) @(posedge ref_clk);
    end
  endtask
endmodule

/* verification/uart_nine_bit_async_baud_tb.sv */
// self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
module uart_nine_bit_async_baud_tb
  import unb_pkg::*;
;
  logic       ref_clk;
  logic       rst_n;
  logic [3:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdData;
  logic       rxdPin;
  logic       txdPin;
  int         mismatches = 0;
  int         checkCount = 0;
  // per rate: baud config, timer 1 reload, control, cycles per bit
  logic [7:0] bdT [6] = '{8'h02, 8'h05, 8'h04, 8'h00, 8'h02, 8'h02};
  logic [7:0] t1T [6] = '{8'h00, 8'hff, 8'hff, 8'hfe, 8'h00, 8'h00};
  logic [7:0] ctT [6] = '{8'h08, 8'h00, 8'h08, 8'h00, 8'h48, 8'h60};
  int         bcT [6] = '{32, 64, 128, 768, 12, 4};

  unb_serial_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .rxdPin(rxdPin), .txdPin(txdPin));
  unb_remote_node node (.ref_clk(ref_clk), .txdPin(txdPin), .rxdLine(rxdPin));

  // clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write; waits an edge when a write just ended
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (regWrite) @(posedge ref_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  // one-cycle read, data judged in the following cycle
  task automatic expRd(input logic [3:0] a, input logic [7:0] e);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    chk({8'h00, regRdData}, {8'h00, e});
  endtask

  // reset values, readback, unmapped reads
  task automatic resetRegs();
    chk({15'h0, txdPin}, 16'h0001);
    for (int a = 0; a < 16; a++) expRd(4'(a), 8'h00);
    wr(ADDR_CONTROL, 8'h0a);
    expRd(ADDR_CONTROL, 8'h0a);
    wr(ADDR_T1RELOAD, 8'h5a);
    expRd(ADDR_T1RELOAD, 8'h5a);
    wr(ADDR_T2LOW, 8'hff);
    expRd(ADDR_T2LOW, 8'hff);
    wr(ADDR_T2HIGH, 8'hff);
  endtask

  // transmit at every baud source and shift rate
  task automatic txRates();
    logic [10:0] f;
    logic [7:0]  dat;
    int          wt;
    for (int i = 0; i < 6; i++) begin
      dat = 8'h96 ^ 8'(i * 37);
      wr(ADDR_BAUD, bdT[i]);
      wr(ADDR_T1RELOAD, t1T[i]);
      wr(ADDR_CONTROL, ctT[i]);
      fork
        node.recv(bcT[i], f, wt);
        begin
          wr(ADDR_BUFFER, dat);
          // start boundary lies within one bit period of the write
          repeat (bcT[i] + 1) @(posedge ref_clk);
          expRd(ADDR_STATUS, 8'h01);
        end
      join
      chk({5'h0, f}, {5'h0, 1'b1, ctT[i][CTL_TX_NINTH], dat, 1'b0});
      chk(16'(wt >= 3 && wt <= bcT[i] + 6), 16'h0001);
      expRd(ADDR_CONTROL, ctT[i] | 8'h02);
    end
  endtask

  // receive: disabled, noisy accept, full flag, multiproc back to back
  task automatic rxCases();
    wr(ADDR_BAUD, 8'h02);
    wr(ADDR_CONTROL, 8'h00);
    node.send(8'h3c, 1'b1, 1'b1, 32, 1'b0);
    expRd(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    fork
      node.send(8'ha5, 1'b1, 1'b1, 32, 1'b1);
      begin
        // receive engine busy well inside the frame
        repeat (100) @(posedge ref_clk);
        expRd(ADDR_STATUS, 8'h02);
      end
    join
    repeat (8) @(posedge ref_clk);
    expRd(ADDR_CONTROL, 8'h15);
    expRd(ADDR_BUFFER, 8'ha5);
    node.send(8'h0f, 1'b0, 1'b1, 32, 1'b0);
    expRd(ADDR_CONTROL, 8'h15);
    expRd(ADDR_BUFFER, 8'ha5);
    wr(ADDR_BAUD, 8'h05);
    wr(ADDR_T1RELOAD, 8'hff);
    wr(ADDR_CONTROL, 8'h30);
    node.send(8'h77, 1'b0, 1'b1, 64, 1'b0);
    node.send(8'h5a, 1'b1, 1'b0, 64, 1'b0);
    repeat (8) @(posedge ref_clk);
    expRd(ADDR_CONTROL, 8'h35);
    expRd(ADDR_BUFFER, 8'h5a);
  endtask

  // counts and verdict, then stop
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n     <= 1'b0;
    regAddr   <= 4'h0;
    regWrData <= 8'h00;
    regWrite  <= 1'b0;
    regRead   <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    resetRegs();
    txRates();
    rxCases();
    wrapUp();
  end

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    wrapUp();
  end
endmodule

bind unb_serial_port unb_port_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .rxdPin(rxdPin), .txdPin(txdPin));
